// ==== hw/process_image_pkg.sv ====
// Package with object map, field layout and carriers of the process image
package process_image_pkg;

  // Object indices and subindices
  localparam logic [15:0] IDX_SLAVE_FRAME = 16'h6000;
  localparam logic [15:0] IDX_SAFETY_INPUT = 16'h6001;
  localparam logic [15:0] IDX_STD_INPUT = 16'h6002;
  localparam logic [15:0] IDX_MASTER_FRAME = 16'h7000;
  localparam logic [15:0] IDX_SAFETY_OUTPUT = 16'h7001;
  localparam logic [15:0] IDX_STD_OUTPUT = 16'h7002;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;
  localparam logic [7:0] SUB_THIRD = 8'h03;

  // Field positions of the input value and status word
  localparam int VALUE_LSB = 0;
  localparam int VALUE_MSB = 7;
  localparam int CONN_BIT = 8;
  localparam int TERM_STATUS_BIT = 9;
  localparam int UNIT_NORMAL_BIT = 10;
  localparam int POWER_FAULT_BIT = 11;
  localparam int RSVD_LSB = 12;
  localparam int RSVD_MSB = 15;

  // Reset values and number of terminals
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int TERMINALS = 8;

  typedef struct packed {
    logic [7:0] command;
    logic [15:0] connection_identifier;
    logic [15:0] check_word;
  } frame_type;

  localparam frame_type FRAME_RESET = '{command: 8'h00, connection_identifier: 16'h0000,
                                        check_word: 16'h0000};

  typedef struct packed {
    logic [TERMINALS-1:0] value;
    logic [TERMINALS-1:0] channel_status;
    logic safety_connection;
    logic terminal_status;
    logic unit_normal;
    logic power_fault;
  } unit_state_type;

  typedef enum {
    OBJ_SLAVE_CMD, OBJ_SLAVE_CONN, OBJ_SLAVE_CHECK, OBJ_SAFETY_IN, OBJ_STD_WORD,
    OBJ_STD_BYTE, OBJ_MASTER_CMD, OBJ_MASTER_CONN, OBJ_MASTER_CHECK, OBJ_SAFETY_OUT,
    OBJ_RSVD_WORD, OBJ_RSVD_BYTE, OBJ_NONE
  } object_type;

  // Maps an index and subindex onto one process image object
  function automatic object_type decode_object(input logic [15:0] index,
                                               input logic [7:0] sub);
    object_type obj;
    obj = OBJ_NONE;
    case (index)
      IDX_SLAVE_FRAME: begin
        if (sub == SUB_FIRST) obj = OBJ_SLAVE_CMD;
        else if (sub == SUB_SECOND) obj = OBJ_SLAVE_CONN;
        else if (sub == SUB_THIRD) obj = OBJ_SLAVE_CHECK;
      end
      IDX_SAFETY_INPUT: if (sub == SUB_FIRST) obj = OBJ_SAFETY_IN;
      IDX_STD_INPUT: begin
        if (sub == SUB_FIRST) obj = OBJ_STD_WORD;
        else if (sub == SUB_SECOND) obj = OBJ_STD_BYTE;
      end
      IDX_MASTER_FRAME: begin
        if (sub == SUB_FIRST) obj = OBJ_MASTER_CMD;
        else if (sub == SUB_SECOND) obj = OBJ_MASTER_CONN;
        else if (sub == SUB_THIRD) obj = OBJ_MASTER_CHECK;
      end
      IDX_SAFETY_OUTPUT: if (sub == SUB_FIRST) obj = OBJ_SAFETY_OUT;
      IDX_STD_OUTPUT: begin
        if (sub == SUB_FIRST) obj = OBJ_RSVD_WORD;
        else if (sub == SUB_SECOND) obj = OBJ_RSVD_BYTE;
      end
      default: obj = OBJ_NONE;
    endcase
    return obj;
  endfunction

endpackage

// ==== hw/safety_input_process_image.sv ====
// Cyclic process image of the eight-channel safety input unit
`timescale 1ns/1ns
module safety_input_process_image (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Unit pins, asynchronous
  input wire logic [process_image_pkg::TERMINALS-1:0] input_terminal,
  input wire logic [process_image_pkg::TERMINALS-1:0] terminal_channel_status,
  input wire logic safety_connection_ok,
  input wire logic terminal_status_ok,
  input wire logic unit_normal,
  input wire logic io_power_fault,
  // Safety protocol engine, same clock
  input wire logic slave_frame_load,
  input wire process_image_pkg::frame_type slave_frame_in,
  input wire logic [15:0] safety_input_in,
  // Cyclic allocation port
  input wire logic cycle_latch,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [15:0] cyc_index,
  input wire logic [7:0] cyc_subindex,
  input wire logic [15:0] cyc_wdata,
  output logic cyc_ack,
  output logic cyc_error,
  output logic [15:0] cyc_rdata,
  // Message access port
  input wire logic msg_valid,
  input wire logic msg_write,
  input wire logic [15:0] msg_index,
  input wire logic [7:0] msg_subindex,
  output logic msg_abort,
  output logic msg_not_here,
  // Data received from the master
  output process_image_pkg::frame_type master_frame,
  output logic [15:0] safety_output_word
);
  import process_image_pkg::*;

  localparam int SYNC_W = 2 * TERMINALS + 4;

  logic [SYNC_W-1:0] sync_first_reg;
  logic [SYNC_W-1:0] sync_second_reg;
  unit_state_type unit_state;
  frame_type slave_frame_reg;
  logic [15:0] safety_input_reg;
  logic [15:0] input_word_reg;
  logic [7:0] channel_byte_reg;
  logic [15:0] input_word_next;
  frame_type master_frame_reg;
  logic [15:0] safety_output_reg;
  object_type cyc_obj;
  object_type msg_obj;
  logic cyc_is_ro;
  logic [15:0] cyc_rdata_next;
  logic msg_write_seen;

  // Two stages before any logic sees the pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_first_reg <= '0;
      sync_second_reg <= '0;
    end else begin
      sync_first_reg <= {input_terminal, terminal_channel_status, safety_connection_ok,
                         terminal_status_ok, unit_normal, io_power_fault};
      sync_second_reg <= sync_first_reg;
    end
  end

  assign unit_state = unit_state_type'(sync_second_reg);

  always_comb begin
    input_word_next = WORD_RESET;
    input_word_next[VALUE_MSB:VALUE_LSB] = unit_state.value;
    input_word_next[CONN_BIT] = unit_state.safety_connection;
    input_word_next[TERM_STATUS_BIT] = unit_state.terminal_status;
    input_word_next[UNIT_NORMAL_BIT] = unit_state.unit_normal;
    input_word_next[POWER_FAULT_BIT] = unit_state.power_fault;
    input_word_next[RSVD_MSB:RSVD_LSB] = 4'h0;
  end

  // Input image frozen at the cycle start so one exchange sees one snapshot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      input_word_reg <= WORD_RESET;
      channel_byte_reg <= BYTE_RESET;
    end else if (cycle_latch) begin
      input_word_reg <= input_word_next;
      channel_byte_reg <= unit_state.channel_status;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slave_frame_reg <= FRAME_RESET;
      safety_input_reg <= WORD_RESET;
    end else if (slave_frame_load) begin
      slave_frame_reg <= slave_frame_in;
      safety_input_reg <= safety_input_in;
    end
  end

  assign cyc_obj = decode_object(cyc_index, cyc_subindex);
  assign msg_obj = decode_object(msg_index, msg_subindex);
  assign cyc_is_ro = (cyc_obj == OBJ_SLAVE_CMD) || (cyc_obj == OBJ_SLAVE_CONN) ||
                     (cyc_obj == OBJ_SLAVE_CHECK) || (cyc_obj == OBJ_SAFETY_IN) ||
                     (cyc_obj == OBJ_STD_WORD) || (cyc_obj == OBJ_STD_BYTE);

  // Only the cyclic port writes; message writes never reach here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      master_frame_reg <= FRAME_RESET;
      safety_output_reg <= WORD_RESET;
    end else if (cyc_valid && cyc_write) begin
      case (cyc_obj)
        OBJ_MASTER_CMD: master_frame_reg.command <= cyc_wdata[7:0];
        OBJ_MASTER_CONN: master_frame_reg.connection_identifier <= cyc_wdata;
        OBJ_MASTER_CHECK: master_frame_reg.check_word <= cyc_wdata;
        OBJ_SAFETY_OUT: safety_output_reg <= cyc_wdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    cyc_rdata_next = WORD_RESET;
    case (cyc_obj)
      OBJ_SLAVE_CMD: cyc_rdata_next = {8'h00, slave_frame_reg.command};
      OBJ_SLAVE_CONN: cyc_rdata_next = slave_frame_reg.connection_identifier;
      OBJ_SLAVE_CHECK: cyc_rdata_next = slave_frame_reg.check_word;
      OBJ_SAFETY_IN: cyc_rdata_next = safety_input_reg;
      OBJ_STD_WORD: cyc_rdata_next = input_word_reg;
      OBJ_STD_BYTE: cyc_rdata_next = {8'h00, channel_byte_reg};
      OBJ_MASTER_CMD: cyc_rdata_next = {8'h00, master_frame_reg.command};
      OBJ_MASTER_CONN: cyc_rdata_next = master_frame_reg.connection_identifier;
      OBJ_MASTER_CHECK: cyc_rdata_next = master_frame_reg.check_word;
      OBJ_SAFETY_OUT: cyc_rdata_next = safety_output_reg;
      OBJ_RSVD_WORD: cyc_rdata_next = WORD_RESET;
      OBJ_RSVD_BYTE: cyc_rdata_next = WORD_RESET;
      default: cyc_rdata_next = WORD_RESET;
    endcase
  end

  // Answer one cycle after the request; writes to read-only objects and any request to unknown objects fail
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cyc_ack <= 1'b0;
      cyc_error <= 1'b0;
      cyc_rdata <= WORD_RESET;
    end else begin
      cyc_ack <= cyc_valid;
      cyc_error <= cyc_valid && ((cyc_obj == OBJ_NONE) || (cyc_write && cyc_is_ro));
      cyc_rdata <= (cyc_valid && !cyc_write) ? cyc_rdata_next : WORD_RESET;
    end
  end

  // Message side sees nothing of the image, only a refusal
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msg_abort <= 1'b0;
      msg_not_here <= 1'b0;
    end else begin
      msg_abort <= msg_valid && (msg_obj != OBJ_NONE);
      msg_not_here <= msg_valid && (msg_obj == OBJ_NONE);
    end
  end

  assign master_frame = master_frame_reg;
  assign safety_output_word = safety_output_reg;

  // Helper for checks: a message write with no cyclic request alongside
  assign msg_write_seen = msg_valid && msg_write && !cyc_valid;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Cyclic port answers
  AST_CYC_ANSWER: assert property (cyc_valid |=> cyc_ack)
    else $error("cyclic request not answered next cycle");
  AST_CYC_QUIET: assert property (!cyc_valid |=>
                                  !cyc_ack && !cyc_error && cyc_rdata == 16'h0000)
    else $error("answer without a cyclic request");
  AST_ERR_WITH_ACK: assert property (cyc_error |-> cyc_ack)
    else $error("error flag raised without an answer");
  AST_RO_WRITE: assert property (cyc_valid && cyc_write && cyc_is_ro |=>
                                 cyc_error && cyc_ack)
    else $error("write to read-only object not flagged");
  AST_WRITE_NO_DATA: assert property (cyc_valid && cyc_write |=> cyc_rdata == 16'h0000)
    else $error("write answered with read data");
  AST_BYTE_UPPER: assert property (cyc_valid && !cyc_write &&
                                   (cyc_obj == OBJ_SLAVE_CMD || cyc_obj == OBJ_STD_BYTE ||
                                   cyc_obj == OBJ_MASTER_CMD) |=> cyc_rdata[15:8] == 8'h00)
    else $error("byte object read with upper byte set");
  AST_WORD_READ: assert property (cyc_valid && !cyc_write &&
                                  cyc_obj == OBJ_STD_WORD |=>
                                  cyc_rdata == $past(input_word_reg))
    else $error("input word read back wrong");
  AST_CHANNEL_READ: assert property (cyc_valid && !cyc_write &&
                                     cyc_obj == OBJ_STD_BYTE |=>
                                     cyc_rdata == {8'h00, $past(channel_byte_reg)})
    else $error("channel status byte read back wrong");
  AST_SAFETY_IN_READ: assert property (cyc_valid && !cyc_write &&
                                       cyc_obj == OBJ_SAFETY_IN |=>
                                       cyc_rdata == $past(safety_input_reg))
    else $error("safety input word read back wrong");
  AST_RSVD_READ: assert property (cyc_valid && (cyc_obj == OBJ_RSVD_WORD ||
                                  cyc_obj == OBJ_RSVD_BYTE) |=>
                                  cyc_rdata == 16'h0000 && !cyc_error)
    else $error("reserved output field did not read zero");

  // Message port
  AST_MSG_REFUSED: assert property (msg_valid && msg_obj != OBJ_NONE |=>
                                    msg_abort && !msg_not_here)
    else $error("message access to image not refused");
  AST_MSG_NOT_HERE: assert property (msg_valid && msg_obj == OBJ_NONE |=>
                                     msg_not_here && !msg_abort)
    else $error("message access elsewhere not answered");
  AST_MSG_QUIET: assert property (!msg_valid |=> !msg_abort && !msg_not_here)
    else $error("message answer without a request");
  AST_MSG_NO_EFFECT: assert property (msg_write_seen |=>
                                      $stable(master_frame_reg) && $stable(safety_output_reg))
    else $error("message write changed the image");

  // Input image
  AST_VALUES: assert property (cycle_latch |=>
                               input_word_reg[7:0] == $past(unit_state.value))
    else $error("terminal values not in bits 0 to 7");
  AST_CONN: assert property (cycle_latch |=>
                             input_word_reg[8] == $past(unit_state.safety_connection))
    else $error("connection status bit wrong");
  AST_TERM: assert property (cycle_latch |=>
                             input_word_reg[9] == $past(unit_state.terminal_status))
    else $error("terminal status bit wrong");
  AST_NORMAL: assert property (cycle_latch |=>
                               input_word_reg[10] == $past(unit_state.unit_normal))
    else $error("unit normal bit wrong");
  AST_POWER: assert property (cycle_latch |=>
                              input_word_reg[11] == $past(unit_state.power_fault))
    else $error("power fault bit wrong");
  AST_RSVD_BITS: assert property (input_word_reg[15:12] == 4'h0)
    else $error("reserved status bits not zero");
  AST_CHANNEL: assert property (cycle_latch |=>
                                channel_byte_reg == $past(unit_state.channel_status))
    else $error("channel status byte wrong");
  AST_IMAGE_HOLD: assert property (!cycle_latch |=>
                                   $stable(input_word_reg) && $stable(channel_byte_reg))
    else $error("input image changed without a latch");

  // Stored objects
  AST_RESET: assert property ($past(!rst_n) |->
                              input_word_reg == 16'h0000 && channel_byte_reg == 8'h00 &&
                              slave_frame_reg == FRAME_RESET && safety_input_reg == 16'h0000 &&
                              master_frame_reg == FRAME_RESET && safety_output_reg == 16'h0000)
    else $error("image not at default after reset");
  AST_SLAVE_LOAD: assert property (slave_frame_load |=>
                                   slave_frame_reg == $past(slave_frame_in) &&
                                   safety_input_reg == $past(safety_input_in))
    else $error("slave frame not loaded");
  AST_SLAVE_HOLD: assert property (!slave_frame_load |=>
                                   $stable(slave_frame_reg) && $stable(safety_input_reg))
    else $error("slave frame changed without a load");
  AST_OUT_WRITE: assert property (cyc_valid && cyc_write &&
                                  cyc_obj == OBJ_SAFETY_OUT |=>
                                  safety_output_reg == $past(cyc_wdata))
    else $error("safety output word not written");
  AST_CMD_WRITE: assert property (cyc_valid && cyc_write &&
                                  cyc_obj == OBJ_MASTER_CMD |=>
                                  master_frame_reg.command == $past(cyc_wdata[7:0]))
    else $error("master command not written");
  AST_CONN_WRITE: assert property (cyc_valid && cyc_write &&
                                   cyc_obj == OBJ_MASTER_CONN |=>
                                   master_frame_reg.connection_identifier == $past(cyc_wdata))
    else $error("master connection identifier not written");
  AST_OUT_HOLD: assert property (!(cyc_valid && cyc_write) |=>
                                 $stable(master_frame_reg) && $stable(safety_output_reg))
    else $error("received objects changed without a cyclic write");
  AST_RSVD_WRITE: assert property (cyc_valid && cyc_write &&
                                   (cyc_obj == OBJ_RSVD_WORD || cyc_obj == OBJ_RSVD_BYTE) |=>
                                   !cyc_error && $stable(master_frame_reg) &&
                                   $stable(safety_output_reg))
    else $error("reserved output write not ignored");

  COV_LATCH: cover property (cycle_latch ##[1:4] cyc_valid && cyc_obj == OBJ_STD_WORD);
  COV_OUT_WRITE: cover property (cyc_valid && cyc_write && cyc_obj == OBJ_SAFETY_OUT);
  COV_MSG: cover property (msg_valid && msg_obj != OBJ_NONE ##1 msg_abort);
  COV_RSVD: cover property (cyc_valid && cyc_write && cyc_obj == OBJ_RSVD_WORD);
  COV_SLAVE_LOAD: cover property (slave_frame_load ##[1:8] cyc_valid && cyc_obj == OBJ_SLAVE_CONN);

endmodule

// ==== verif/cyclic_master.sv ====
// Behavioural safety master issuing cyclic and message requests
`timescale 1ns/1ns
module cyclic_master (
  // Clock
  input wire logic clock,
  // Cyclic requests
  output logic cyc_valid,
  output logic cyc_write,
  output logic [15:0] cyc_index,
  output logic [7:0] cyc_subindex,
  output logic [15:0] cyc_wdata,
  // Message requests
  output logic msg_valid,
  output logic msg_write,
  output logic [15:0] msg_index,
  output logic [7:0] msg_subindex
);
  import process_image_pkg::*;
  initial begin
    {cyc_valid, cyc_write, cyc_index, cyc_subindex, cyc_wdata} = '0;
    {msg_valid, msg_write, msg_index, msg_subindex} = '0;
  end
  task automatic req(input logic m, input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [15:0] d);
    @(negedge clock);
    cyc_valid = !m;
    msg_valid = m;
    cyc_write = w;
    msg_write = w;
    cyc_index = i;
    msg_index = i;
    cyc_subindex = s;
    msg_subindex = s;
    // Reserved output objects only ever carry zero
    cyc_wdata = (i == IDX_STD_OUTPUT) ? 16'h0000 : d;
  endtask
  task automatic idle();
    @(negedge clock);
    cyc_valid = 1'b0;
    msg_valid = 1'b0;
    // Stale write data must not look valid
    cyc_wdata = ~cyc_wdata;
  endtask
endmodule

// ==== verif/safety_input_process_image_bench.sv ====
// Self-checking bench of the safety input process image
`timescale 1ns/1ns
module safety_input_process_image_bench;
  import process_image_pkg::*;
  localparam logic [18:0] ERR = 19'h40000, WOK = 19'h00000, ABT = 19'h00002, NH = 19'h00001;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] input_terminal = 8'h00;
  logic [7:0] terminal_channel_status = 8'h00;
  logic safety_connection_ok = 1'b0, terminal_status_ok = 1'b0, unit_normal = 1'b0;
  logic io_power_fault = 1'b0, slave_frame_load = 1'b0, cycle_latch = 1'b0;
  frame_type slave_frame_in = FRAME_RESET;
  logic [15:0] safety_input_in = 16'h0000;
  logic cyc_valid, cyc_write, msg_valid, msg_write, cyc_ack, cyc_error, msg_abort, msg_not_here;
  logic [15:0] cyc_index, cyc_wdata, msg_index, cyc_rdata, safety_output_word;
  logic [7:0] cyc_subindex, msg_subindex;
  frame_type master_frame;
  logic [18:0] expq [$];
  logic [18:0] mon_e;
  logic [31:0] r;
  logic [15:0] img [12] = '{default: 16'h0000};
  logic [23:0] objs [12] = '{24'h600001, 24'h600002, 24'h600003, 24'h600101, 24'h600201,
    24'h600202, 24'h700001, 24'h700002, 24'h700003, 24'h700101, 24'h700201, 24'h700202};
  int failures = 0;
  int n_checks = 0;
  int seed = 97081;
  always #2 clock = ~clock;
  safety_input_process_image u_safety_input_process_image (.clock(clock), .rst_n(rst_n),
    .input_terminal(input_terminal), .terminal_channel_status(terminal_channel_status),
    .safety_connection_ok(safety_connection_ok), .terminal_status_ok(terminal_status_ok),
    .unit_normal(unit_normal), .io_power_fault(io_power_fault),
    .slave_frame_load(slave_frame_load), .slave_frame_in(slave_frame_in),
    .safety_input_in(safety_input_in), .cycle_latch(cycle_latch), .cyc_valid(cyc_valid),
    .cyc_write(cyc_write), .cyc_index(cyc_index), .cyc_subindex(cyc_subindex),
    .cyc_wdata(cyc_wdata), .cyc_ack(cyc_ack), .cyc_error(cyc_error), .cyc_rdata(cyc_rdata),
    .msg_valid(msg_valid), .msg_write(msg_write), .msg_index(msg_index),
    .msg_subindex(msg_subindex), .msg_abort(msg_abort), .msg_not_here(msg_not_here),
    .master_frame(master_frame), .safety_output_word(safety_output_word));
  cyclic_master u_cyclic_master (.clock(clock), .cyc_valid(cyc_valid), .cyc_write(cyc_write),
    .cyc_index(cyc_index), .cyc_subindex(cyc_subindex), .cyc_wdata(cyc_wdata),
    .msg_valid(msg_valid), .msg_write(msg_write), .msg_index(msg_index),
    .msg_subindex(msg_subindex));
  function automatic logic [18:0] rd(input logic [15:0] v);
    return {1'b0, v, 2'b00};
  endfunction
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic m, input logic w, input logic [23:0] a,
                     input logic [15:0] d, input logic [18:0] e);
    u_cyclic_master.req(m, w, a[23:8], a[7:0], d);
    expq.push_back(e);
  endtask
  task automatic read_all();
    for (int k = 0; k < 12; k++) acc(1'b0, 1'b0, objs[k], 16'h0000, rd(img[k]));
    u_cyclic_master.idle();
  endtask
  task automatic sample_pins();
    r = $random(seed);
    u_cyclic_master.idle();
    {safety_connection_ok, terminal_status_ok, unit_normal, io_power_fault} = r[19:16];
    {terminal_channel_status, input_terminal} = r[15:0];
    // Two sync flops plus margin before the snapshot
    repeat (4) @(negedge clock);
    cycle_latch = 1'b1;
    @(negedge clock);
    cycle_latch = 1'b0;
    img[4] = {4'h0, r[16], r[17], r[18], r[19], r[7:0]};
    img[5] = {8'h00, r[15:8]};
  endtask
  task automatic end_of_test();
    if (expq.size() != 0) failures++;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Answers stand one cycle, so look at every falling edge
  always @(negedge clock) begin
    if (rst_n && (cyc_ack || msg_abort || msg_not_here)) begin
      mon_e = (expq.size() > 0) ? expq.pop_front() : 19'h7FFFF;
      check({cyc_error, cyc_rdata, msg_abort, msg_not_here}, mon_e);
    end
  end
  initial begin
    #40000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    // Live pins before any latch must not reach the image
    r = $random(seed);
    {safety_connection_ok, terminal_status_ok, unit_normal, io_power_fault} = r[19:16];
    {terminal_channel_status, input_terminal} = r[15:0];
    read_all();
    acc(1'b0, 1'b0, 24'h600000, 16'h0000, ERR);
    acc(1'b0, 1'b0, 24'h700400, 16'h0000, ERR);
    $display("test defaults done");
    repeat (4) begin
      sample_pins();
      acc(1'b0, 1'b0, objs[4], 16'h0000, rd(img[4]));
      acc(1'b0, 1'b0, objs[5], 16'h0000, rd(img[5]));
    end
    $display("test input image done");
    r = $random(seed);
    u_cyclic_master.idle();
    slave_frame_in = {r[7:0], r[31:16], r[15:0]};
    safety_input_in = r[23:8];
    slave_frame_load = 1'b1;
    @(negedge clock);
    slave_frame_load = 1'b0;
    img[0] = {8'h00, r[7:0]};
    img[1] = r[31:16];
    img[2] = r[15:0];
    img[3] = r[23:8];
    acc(1'b0, 1'b1, objs[3], 16'hFFFF, ERR);
    acc(1'b0, 1'b1, objs[1], 16'hFFFF, ERR);
    read_all();
    $display("test slave frame done");
    for (int k = 6; k < 12; k++) begin
      r = $random(seed);
      img[k] = (k > 9) ? 16'h0000 : (k == 6) ? {8'h00, r[7:0]} : r[15:0];
      acc(1'b0, 1'b1, objs[k], r[15:0], WOK);
    end
    read_all();
    check(master_frame, {img[6][7:0], img[7], img[8]});
    check({24'h0, safety_output_word}, {24'h0, img[9]});
    $display("test master objects done");
    for (int k = 0; k < 12; k++) acc(1'b1, k[0], objs[k], 16'hA5A5, ABT);
    acc(1'b1, 1'b0, 24'h500001, 16'h0000, NH);
    read_all();
    $display("test message refusal done");
    @(negedge clock);
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    img = '{default: 16'h0000};
    read_all();
    $display("test second reset done");
    @(negedge clock);
    end_of_test();
  end
endmodule
